/* verilog/mbrc_top.sv */
// Purpose: reset distribution and pll reset sequencing for a three-port bridge
// Assumes: straps static; pll lock inputs asynchronous; one 200 MHz clock
// Notes:   bus reset pins are three signals; oe low means the pin is driven
//
// Summary of operation
// RQ1: resets are active low except board_ok
// RQ2: direction strap 0 input, 1 output
// RQ3: input-side bus reset drives output-side pins
// RQ4: each reset source clears its own scope
// RQ5: reset effect independent of pin direction
// RQ6: output pins still sensed, local reset
// RQ7: only input pins propagate to other buses
// RQ8: reset inputs act asynchronously; bus reset pins pass the synchroniser first
// RQ9: pll reset only by por/board_ok; wait lock
// RQ10: system asserts board_ok before por release
// RQ11: board_ok negated floats outputs, ignores inputs
// RQ12: test reset clears tap, scan passes through
// RQ13: system asserts test reset with por
// RQ14: output bus reset on por or input reset
// RQ15: bus reset outputs held until plls lock
// RQ16: per-port state machines on own pll clock
// RQ17: system runs port clocks before por release
// RQ18: per-pll range from own range pin
// RQ19: bypass option skips all three plls
// RQ20: range pins latched on por rising edge
module mbrc_top #(
  parameter int unsigned LOCK_CYC = mbrc_pkg::LOCK_SETTLE_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       power_on_reset_n_i,
  input  wire logic       board_ok_i,
  input  wire logic       test_reset_n_i,
  input  wire logic       cpu_bus_reset_dir_i,
  input  wire logic       pci_a_reset_dir_i,
  input  wire logic       pci_b_reset_dir_i,
  input  wire logic       cpu_bus_reset_n_i,
  input  wire logic       pci_a_reset_n_i,
  input  wire logic       pci_b_reset_n_i,
  input  wire logic       cpu_bus_pll_range_i,
  input  wire logic       pci_a_pll_range_i,
  input  wire logic       pci_b_pll_range_i,
  input  wire logic       pll_bypass_i,
  input  wire logic [2:0] pll_lock_i,
  output logic            cpu_bus_reset_n_o,
  output logic            pci_a_reset_n_o,
  output logic            pci_b_reset_n_o,
  output logic            cpu_bus_reset_oe_n_o,
  output logic            pci_a_reset_oe_n_o,
  output logic            pci_b_reset_oe_n_o,
  output logic            outputs_float_o,
  output logic            inputs_ignore_o,
  output logic [2:0]      pll_reset_o,
  output logic [2:0]      pll_range_o,
  output logic            pll_bypass_o,
  output logic            cpu_regs_rst_n_o,
  output logic            pci_a_regs_rst_n_o,
  output logic            pci_b_regs_rst_n_o,
  output logic            dev_regs_rst_n_o,
  output logic [2:0]      fsm_rst_n_o,
  output logic            tap_rst_n_o,
  output logic            scan_normal_o
);
  // the check below keeps the settle counter meaningful
  initial begin
    if (LOCK_CYC < 1) $error("LOCK_CYC must be at least one");
  end

  // raw asynchronous conditions; these never wait for a clock edge
  wire hard_rst_raw = !power_on_reset_n_i || !board_ok_i; // RQ1 RQ8
  // por and board faults clear the held resets at once; release stays synchronous
  wire hard_arst_n  = nrst_i && !hard_rst_raw; // RQ8
  wire [2:0] dir    = {pci_b_reset_dir_i, pci_a_reset_dir_i, cpu_bus_reset_dir_i}; // RQ2
  wire [2:0] pin_n  = {pci_b_reset_n_i, pci_a_reset_n_i, cpu_bus_reset_n_i};

  // synchronised copies drive the sequencer and the bus pin sensing
  logic       por_n_s;
  logic       ok_s;
  logic [2:0] pin_n_s;
  logic [2:0] lock_s;

  mbrc_sync #(.RESET_VAL(1'b0)) u_sync_por (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (power_on_reset_n_i),
    .sync_o  (por_n_s)
  );
  mbrc_sync #(.RESET_VAL(1'b0)) u_sync_ok (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (board_ok_i),
    .sync_o  (ok_s)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      mbrc_sync #(.RESET_VAL(1'b0)) u_pin (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (pin_n[g]),
        .sync_o  (pin_n_s[g])
      );
      mbrc_sync #(.RESET_VAL(1'b0)) u_lock (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (pll_lock_i[g]),
        .sync_o  (lock_s[g])
      );
    end
  endgenerate

  wire hard_rst_s = !por_n_s || !ok_s;

  // sequencer: pll reset, wait for all locks, run
  mbrc_pkg::mbrc_seq_e state;
  mbrc_pkg::mbrc_seq_e next_state;
  logic                lock_done;
  wire                 all_locked = &lock_s;

  mbrc_lock_wait #(.COUNT(LOCK_CYC)) u_lock_wait (
    .clk_i        (clk_i),
    .nrst_i       (nrst_i),
    .start_i      (state == mbrc_pkg::MBRC_WAIT_LOCK),
    .all_locked_i (all_locked),
    .done_o       (lock_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      mbrc_pkg::MBRC_PLL_RESET: begin
        if (!hard_rst_s) begin
          next_state = mbrc_pkg::MBRC_WAIT_LOCK;
        end
      end
      mbrc_pkg::MBRC_WAIT_LOCK: begin
        if (hard_rst_s) begin
          next_state = mbrc_pkg::MBRC_PLL_RESET;
        end else if (lock_done || pll_bypass_o) begin // RQ9 RQ19
          next_state = mbrc_pkg::MBRC_RUN;
        end
      end
      mbrc_pkg::MBRC_RUN: begin
        if (hard_rst_s) begin
          next_state = mbrc_pkg::MBRC_PLL_RESET;
        end
      end
      default: next_state = mbrc_pkg::MBRC_PLL_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= mbrc_pkg::MBRC_PLL_RESET;
      pll_reset_o <= 3'h7;
    end else begin
      state       <= next_state;
      // pll reset follows the sequencer, so a pin glitch cannot pulse it
      pll_reset_o <= {3{state == mbrc_pkg::MBRC_PLL_RESET}}; // RQ9
    end
  end

  // held reset: asynchronous entry, release only when sequencer runs
  logic hold_n;
  always_ff @(posedge clk_i or negedge hard_arst_n) begin
    if (!hard_arst_n) begin
      hold_n <= 1'b0;
    end else begin
      hold_n <= (state == mbrc_pkg::MBRC_RUN) && !hard_rst_s; // RQ9 RQ15
    end
  end
  // hold_n is cleared asynchronously by por or a board fault
  wire global_n = hold_n; // RQ4 RQ9

  // range and bypass latch on the por rising edge, seen synchronously
  logic por_n_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      por_n_q <= 1'b0;
    end else begin
      por_n_q <= por_n_s;
    end
  end
  wire por_rise = por_n_s && !por_n_q;
  // raw strap pins, sampled only once the por synchroniser has passed; hold time on the pins covers it
  wire [2:0] range_pins = {pci_b_pll_range_i, pci_a_pll_range_i, cpu_bus_pll_range_i};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pll_range_o  <= mbrc_pkg::RANGE_RESET;
      pll_bypass_o <= mbrc_pkg::BYPASS_RESET;
    end else if (por_rise) begin
      pll_range_o  <= range_pins;    // RQ18 RQ20
      pll_bypass_o <= pll_bypass_i;  // RQ19
    end
  end

  // bus reset sensing and propagation
  // pins pass the synchroniser too; costs about four cycles of latency
  wire [2:0] pin_low  = ~pin_n_s;     // RQ5 RQ6
  wire [2:0] src_low  = pin_low & ~dir; // RQ7
  function automatic logic [2:0] others(input logic [2:0] v);
    others = {v[0] | v[1], v[0] | v[2], v[1] | v[2]};
  endfunction
  wire [2:0] prop     = others(src_low); // RQ3
  // drive asserted: por, held sequencing, or propagation from an input pin
  wire [2:0] drive_lo = dir & ({3{!global_n}} | prop); // RQ14 RQ15

  // per-bus scopes
  wire [2:0] bus_n    = ~pin_low & {3{global_n}};
  wire       any_bus  = |pin_low;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {pci_b_reset_n_o, pci_a_reset_n_o, cpu_bus_reset_n_o} <= 3'h0;
      {pci_b_reset_oe_n_o, pci_a_reset_oe_n_o, cpu_bus_reset_oe_n_o} <= 3'h7;
      outputs_float_o <= 1'b1;
      inputs_ignore_o <= 1'b1;
    end else begin
      {pci_b_reset_n_o, pci_a_reset_n_o, cpu_bus_reset_n_o} <= 3'h0;
      // oe low drives low; open-drain style for all three
      {pci_b_reset_oe_n_o, pci_a_reset_oe_n_o, cpu_bus_reset_oe_n_o} <=
        ok_s ? ~drive_lo : 3'h7; // RQ2 RQ11
      outputs_float_o <= !ok_s; // RQ11
      inputs_ignore_o <= !ok_s; // RQ11
    end
  end

  // scoped reset outputs: asynchronous assert through the async reset path
  // reset branch holds constants only; hard_arst_n carries the async entry
  always_ff @(posedge clk_i or negedge hard_arst_n) begin
    if (!hard_arst_n) begin
      cpu_regs_rst_n_o   <= 1'b0;
      pci_a_regs_rst_n_o <= 1'b0;
      pci_b_regs_rst_n_o <= 1'b0;
      dev_regs_rst_n_o   <= 1'b0;
      fsm_rst_n_o        <= 3'h0;
    end else begin
      cpu_regs_rst_n_o   <= bus_n[mbrc_pkg::BUS_CPU];   // RQ4
      pci_a_regs_rst_n_o <= bus_n[mbrc_pkg::BUS_PCI_A]; // RQ4
      pci_b_regs_rst_n_o <= bus_n[mbrc_pkg::BUS_PCI_B]; // RQ4
      dev_regs_rst_n_o   <= global_n && !any_bus;       // RQ4
      fsm_rst_n_o        <= {3{global_n && !any_bus}};  // RQ4 RQ16
    end
  end

  // test reset path, independent of the sequencer
  always_ff @(posedge clk_i or negedge test_reset_n_i) begin
    if (!test_reset_n_i) begin
      tap_rst_n_o   <= 1'b0; // RQ12
      scan_normal_o <= 1'b1; // RQ12
    end else begin
      tap_rst_n_o   <= 1'b1;
      scan_normal_o <= 1'b1;
    end
  end

  // checks
  int unsigned run_guard;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_guard <= 0;
    end else begin
      run_guard <= (state == mbrc_pkg::MBRC_RUN) ? run_guard + 1 : 0;
    end
  end
  sequence s_lock_released;
    !hard_rst_s && all_locked;
  endsequence

  AST_NO_RUN_WITHOUT_LOCK: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ9
    $rose(state == mbrc_pkg::MBRC_RUN) |-> (all_locked || pll_bypass_o))
    else $error("run entered without lock");
  AST_PLL_RESET_ONLY_HARD: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ9
    $rose(pll_reset_o[0]) |-> $past(hard_rst_s, 2))
    else $error("pll reset without por or board fault");
  AST_FLOAT_ON_FAULT: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ11
    !ok_s |=> (outputs_float_o && &{pci_b_reset_oe_n_o, pci_a_reset_oe_n_o,
                                   cpu_bus_reset_oe_n_o}))
    else $error("outputs not floated");
  AST_INPUT_PIN_NEVER_DRIVEN: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ2
    (!cpu_bus_reset_dir_i && $stable(cpu_bus_reset_dir_i)) |=> cpu_bus_reset_oe_n_o)
    else $error("input pin driven");
  AST_PROPAGATE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ3
    (ok_s && pci_a_reset_dir_i && !cpu_bus_reset_dir_i && !pin_n_s[mbrc_pkg::BUS_CPU])
      |=> !pci_a_reset_oe_n_o)
    else $error("reset not propagated");
  // lows on output pins alone must never drive any pin
  AST_NO_PROP_FROM_OUTPUT: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ7
    (ok_s && global_n && ((pin_low & ~dir) == 3'h0))
      |=> &{pci_b_reset_oe_n_o, pci_a_reset_oe_n_o, cpu_bus_reset_oe_n_o})
    else $error("output pin propagated");
  AST_LOCAL_SCOPE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ4
    !pin_n_s[mbrc_pkg::BUS_PCI_A] |=> (!pci_a_regs_rst_n_o && !dev_regs_rst_n_o))
    else $error("pci a scope not reset");
  AST_HOLD_UNTIL_RUN: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ15
    s_lock_released ##0 (state != mbrc_pkg::MBRC_RUN) |=> !hold_n)
    else $error("reset released early");
  AST_RUN_STABLE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RQ9
    (run_guard > 2 && !hard_rst_s) |-> pll_reset_o == 3'h0)
    else $error("pll reset during run");
endmodule

/* verilog/mbrc_pkg.sv */
// Purpose: shared constants for the multi-bus reset controller
// Assumes: single 200 MHz clock, asynchronous active-low reset
// Notes:   resource indices name the reset scopes driven out
package mbrc_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  // settle time after every pll reports lock before lock is trusted
  localparam int unsigned LOCK_SETTLE_NS   = 100;
  localparam int unsigned LOCK_SETTLE_CYC  =
    (LOCK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_STAGES      = 3;
  localparam int unsigned NUM_BUS          = 3;
  localparam int unsigned BUS_CPU          = 0;
  localparam int unsigned BUS_PCI_A        = 1;
  localparam int unsigned BUS_PCI_B        = 2;
  localparam logic [2:0]  RANGE_RESET      = 3'h0;
  localparam logic        BYPASS_RESET     = 1'h0;
  typedef enum logic [2:0] {
    MBRC_PLL_RESET = 3'h1,
    MBRC_WAIT_LOCK = 3'h2,
    MBRC_RUN       = 3'h4
  } mbrc_seq_e;
endpackage

/* verilog/mbrc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk_i
// Notes:   stage one feeds stage two only
module mbrc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic s1;
  logic s2;
  logic s3;
  wire  agree = (s2 == s3);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1     <= RESET_VAL;
      s2     <= RESET_VAL;
      s3     <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        sync_o <= s3;
      end
    end
  end
endmodule

/* verilog/mbrc_lock_wait.sv */
// Purpose: counts settle cycles once every pll reports lock
// Assumes: lock inputs already synchronised
// Notes:   a lost lock restarts the count
module mbrc_lock_wait #(
  parameter int unsigned COUNT = 20
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic all_locked_i,
  output logic      done_o
);
  localparam int unsigned CW = (COUNT > 1) ? $clog2(COUNT + 1) : 1;
  logic [CW-1:0] cnt;
  wire           at_end = (cnt == CW'(COUNT));
  initial begin
    if (COUNT < 1) $error("lock wait count must be at least one");
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else if (!start_i || !all_locked_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else if (!at_end) begin
      cnt    <= cnt + CW'(1);
    end else begin
      done_o <= 1'b1;
    end
  end
endmodule

/* dv/mbrc_bus_model.sv */
// Purpose: bus reset wires and pll lock model facing the reset controller
// Assumes: every bus reset wire has a pull-up
// Notes:   hold_i keeps all plls unlocked to stretch the wait
module mbrc_bus_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] oe_n_i,
  input  wire logic [2:0] drv_i,
  input  wire logic [2:0] ext_i,
  input  wire logic [2:0] pll_reset_i,
  input  wire logic       hold_i,
  output logic [2:0]      wire_o,
  output logic [2:0]      lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt [3] = '{default: 4'h0};
  // released wire floats up, never keeps the last driven value
  assign wire_o = ~((~oe_n_i & ~drv_i) | ext_i);
  // staggered lock so the last pll decides the release
  // port clocks run from the start, well before por is released
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (pll_reset_i[i] || hold_i) begin
        cnt[i] <= 4'h0;
      end else if (cnt[i] != 4'hF) begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
  assign lock_o = {cnt[2] > 4'h7, cnt[1] > 4'h5, cnt[0] > 4'h3};
endmodule

/* dv/mbrc_top_bench.sv */
// Purpose: self-checking bench for the reset controller
// Assumes: direction and bypass straps change only under power-on reset; range straps flip after release
// Notes:   lock settle shortened to 2 cycles
module mbrc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, nrst_i, power_on_reset_n_i, board_ok_i, test_reset_n_i;
  logic       pll_bypass_i, pll_bypass_o, hold, outputs_float_o, inputs_ignore_o;
  logic       cpu_bus_reset_n_o, pci_a_reset_n_o, pci_b_reset_n_o, dev_regs_rst_n_o;
  logic       cpu_bus_reset_oe_n_o, pci_a_reset_oe_n_o, pci_b_reset_oe_n_o;
  logic       cpu_regs_rst_n_o, pci_a_regs_rst_n_o, pci_b_regs_rst_n_o;
  logic       tap_rst_n_o, scan_normal_o;
  logic [2:0] dir, rng, ext, oe_n, drv, pins, lock, rr;
  logic [2:0] pll_reset_o, pll_range_o, fsm_rst_n_o;
  int         n_errors, n_checks, n_cyc;

  assign oe_n = {pci_b_reset_oe_n_o, pci_a_reset_oe_n_o, cpu_bus_reset_oe_n_o};
  assign drv  = {pci_b_reset_n_o, pci_a_reset_n_o, cpu_bus_reset_n_o};
  assign rr   = {pci_b_regs_rst_n_o, pci_a_regs_rst_n_o, cpu_regs_rst_n_o};

  mbrc_top #(.LOCK_CYC(2)) u_dut (
    .clk_i, .nrst_i, .power_on_reset_n_i, .board_ok_i, .test_reset_n_i,
    .cpu_bus_reset_dir_i(dir[0]), .pci_a_reset_dir_i(dir[1]), .pci_b_reset_dir_i(dir[2]),
    .cpu_bus_reset_n_i(pins[0]), .pci_a_reset_n_i(pins[1]), .pci_b_reset_n_i(pins[2]),
    .cpu_bus_pll_range_i(rng[0]), .pci_a_pll_range_i(rng[1]), .pci_b_pll_range_i(rng[2]),
    .pll_bypass_i, .pll_lock_i(lock), .cpu_bus_reset_n_o, .pci_a_reset_n_o,
    .pci_b_reset_n_o, .cpu_bus_reset_oe_n_o, .pci_a_reset_oe_n_o, .pci_b_reset_oe_n_o,
    .outputs_float_o, .inputs_ignore_o, .pll_reset_o, .pll_range_o, .pll_bypass_o,
    .cpu_regs_rst_n_o, .pci_a_regs_rst_n_o, .pci_b_regs_rst_n_o, .dev_regs_rst_n_o,
    .fsm_rst_n_o, .tap_rst_n_o, .scan_normal_o
  );

  mbrc_bus_model u_net (
    .clk_i, .oe_n_i(oe_n), .drv_i(drv), .ext_i(ext), .pll_reset_i(pll_reset_o),
    .hold_i(hold), .wire_o(pins), .lock_o(lock)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // por cycle with locks held off, then released
  task automatic power_up(input logic [2:0] d, input logic [2:0] r, input logic b);
    power_on_reset_n_i = 1'b0;
    test_reset_n_i = 1'b0;
    dir = d;
    rng = r;
    pll_bypass_i = b;
    hold = 1'b1;
    cyc(10);
    chk("pll_reset", pll_reset_o, 3'h7);
    chk("regs", rr, 3'h0);
    chk("fsm", fsm_rst_n_o, 3'h0);
    chk("dev_tap_scan", {dev_regs_rst_n_o, tap_rst_n_o, scan_normal_o}, 3'h1);
    chk("oe_n", oe_n, ~d);
    chk("drv", drv, 3'h0);
    power_on_reset_n_i = 1'b1;
    test_reset_n_i = 1'b1;
    cyc(8);
    rng = ~r;
    cyc(30);
    chk("range", pll_range_o, r);
    chk("bypass", {2'h0, pll_bypass_o}, {2'h0, b});
    if (!b) begin
      chk("oe_n held", oe_n, ~d);
      chk("regs held", rr, 3'h0);
    end
    hold = 1'b0;
    cyc(40);
    chk("oe_n run", oe_n, 3'h7);
    chk("regs run", rr, 3'h7);
    chk("fsm run", fsm_rst_n_o, 3'h7);
    chk("pll run", pll_reset_o, 3'h0);
    chk("tap run", {1'b0, tap_rst_n_o, scan_normal_o}, 3'h3);
  endtask

  // reset entering on an input pin reaches every output pin
  task automatic t_in_prop(input logic [2:0] e, input logic [2:0] exp_oe);
    ext = e;
    cyc(12);
    chk("prop oe_n", oe_n, exp_oe);
    chk("prop regs", rr, 3'h0);
    chk("prop pll", pll_reset_o, 3'h0);
    ext = 3'h0;
    cyc(12);
    chk("prop end", oe_n & rr, 3'h7);
  endtask

  // low seen on an output pin stays in its own scope
  task automatic t_out_local;
    for (int i = 1; i < 3; i++) begin
      ext = 3'h1 << i;
      cyc(12);
      chk("local oe_n", oe_n, 3'h7);
      chk("local regs", rr, ~ext);
      chk("local dev", {dev_regs_rst_n_o, pll_reset_o[1:0]}, 3'h0);
      ext = 3'h0;
      cyc(12);
      chk("local end", rr, 3'h7);
    end
  endtask

  // board not ok floats every pin, even with an input reset active
  task automatic t_board;
    board_ok_i = 1'b0;
    ext = 3'h1;
    cyc(12);
    chk("float", {outputs_float_o, inputs_ignore_o, dev_regs_rst_n_o}, 3'h6);
    chk("float oe_n", oe_n, 3'h7);
    chk("float pll", pll_reset_o, 3'h7);
    ext = 3'h0;
    board_ok_i = 1'b1;
    cyc(60);
    chk("back regs", rr, 3'h7);
    chk("back oe", {outputs_float_o, oe_n[1:0]}, 3'h3);
  endtask

  // hang guard, roughly eight times the expected run
  always @(posedge clk_i) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    nrst_i = 1'b0;
    power_on_reset_n_i = 1'b0;
    board_ok_i = 1'b1;
    test_reset_n_i = 1'b0;
    pll_bypass_i = 1'b0;
    hold = 1'b1;
    dir = 3'h6;
    rng = 3'h5;
    ext = 3'h0;
    cyc(16);
    nrst_i = 1'b1;
    power_up(3'h6, 3'h5, 1'b0);
    t_in_prop(3'h1, 3'h1);
    t_out_local();
    t_board();
    power_up(3'h3, 3'h2, 1'b1);
    t_in_prop(3'h4, 3'h4);
    wrap_up();
  end
endmodule
